// ---- hw/fbwa_write_ctrl.sv ----
// Write path control of the nonvolatile array block with busy and status
// ----------------------------------------
// Behaviour
// R01 - 64 sectors, 32 pages plus spare each
// R02 - Page: eight 16-byte blocks plus 4-byte aux
// R03 - Address: sector 17:12, page 11:7, block, byte
// R04 - Spare page select ignores page field
// R05 - Aux block select ignores bits 6:2
// R06 - Sector zero spare write errors, reads zero
// R07 - Operations accepted only while busy low
// R08 - Requester starts write with strobe while idle
// R09 - Page miss copy: busy at least 55 cycles
// R10 - Copy: nine blocks, 5+1 cycles, 1 reload
// R11 - Same loaded block writes: no busy
// R12 - Other block: busy 4, or 5 pipelined
// R13 - Status 00 success, nonzero means not written
// R14 - Status holds until next operation starts
// R15 - One word per write, width selectable
// R16 - Any order writes, partial page allowed
// R17 - Protected page write refused, status 01
// R18 - Loss protection miss refused, status 11
// R19 - Requester tracks buffer contents and commits
// ----------------------------------------
// Limitations
// ----------------------------------------
// Array contents are not modelled; a page copy costs time only
// A strobe during busy is dropped, so the requester must retry
// Protection inputs are levels taken with the strobe, not latched
// Lanes past the end of a block drop rather than wrap around
// Status 10 marks the reserved spare page, a local code choice
// ----------------------------------------
`timescale 1ns/100ps
module fbwa_write_ctrl #(
	parameter int PREFETCH_EXTRA = fbwa_pkg::BLK_READ_CYC // Wait for in-flight read
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_wen,
	input wire logic [fbwa_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fbwa_pkg::DATA_W-1:0] i_wdata,
	input wire logic [1:0] i_word_width_select,
	input wire logic i_spare_page_select,
	input wire logic i_aux_block_select,
	input wire logic i_pipe,
	input wire logic i_page_protected,
	input wire logic i_page_loss_protect,
	input wire logic i_prefetch_active,
	input wire logic [fbwa_pkg::BUF_IDX_W-1:0] i_peek_index,
	output logic o_busy,
	output logic [1:0] o_status,
	output logic o_buf_valid,
	output logic [fbwa_pkg::SECTOR_W-1:0] o_buf_sector,
	output logic [fbwa_pkg::PAGE_W-1:0] o_buf_page,
	output logic o_buf_spare,
	output logic [7:0] o_peek_data
);
	import fbwa_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	// All control state of the write path
	typedef struct packed {
		fbwa_state_t state; // Sequencer state
		logic [CNT_W-1:0] cnt; // Busy cycles left minus one
		logic busy; // Registered busy
		logic [1:0] status; // Sticky result
		logic buf_valid; // Page buffer holds a page
		logic [SECTOR_W-1:0] sector; // Buffered sector
		logic [PAGE_W-1:0] page; // Buffered page
		logic spare; // Buffered page is the spare
		logic blk_valid; // Block buffer loaded
		logic [BLOCK_W-1:0] blk; // Loaded block
	} fbwa_ctrl_t;
	fbwa_ctrl_t st_r;
	fbwa_ctrl_t st_nxt;

	// Decoded fields of the current request
	logic [SECTOR_W-1:0] dec_sector;
	logic [PAGE_W-1:0] dec_page;
	logic [BLOCK_W-1:0] dec_block;
	logic [BYTE_W-1:0] dec_byte;
	logic dec_spare0;
	// Request qualifiers
	logic acc; // Write taken this cycle
	logic pg_hit; // Target page is buffered
	logic blk_hit; // Target block is loaded
	logic [1:0] err; // Result code of the request
	logic buf_we; // Store the word

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Sector count and page count fit the field widths
	fbwa_addr_decode u_dec (
		.i_addr(i_addr),
		.i_spare_page_select(i_spare_page_select),
		.i_aux_block_select(i_aux_block_select),
		.o_sector(dec_sector), // see R01
		.o_page(dec_page),
		.o_block(dec_block),
		.o_byte(dec_byte),
		.o_spare0(dec_spare0)
	);

	// ----------------------------------------
	// Request qualification
	// ----------------------------------------
	// Strobes while busy are dropped, not queued
	assign acc = i_wen && !st_r.busy; // see R07 see R08
	// Spare flag takes part in the match, page field is zero there
	assign pg_hit = st_r.buf_valid && (dec_sector == st_r.sector)
		&& (dec_page == st_r.page) && (i_spare_page_select == st_r.spare);
	assign blk_hit = pg_hit && st_r.blk_valid && (dec_block == st_r.blk);

	// Error priority: reserved page, then protection, then loss guard
	always_comb begin
		if (dec_spare0) begin
			err = ST_SPARE0; // see R06
		end else if (i_page_protected) begin
			err = ST_PROTECT; // see R17
		end else if (i_page_loss_protect && !pg_hit) begin
			err = ST_LOSS; // see R18
		end else begin
			err = ST_OK; // see R13
		end
	end

	// Word goes into the buffer at acceptance; a refused one never does
	assign buf_we = acc && (err == ST_OK); // see R13

	// ----------------------------------------
	// Page buffer
	// ----------------------------------------
	// Any address, any order; no need to fill the page
	fbwa_page_buffer u_pbuf (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_we(buf_we), // see R16
		.i_aux(i_aux_block_select),
		.i_index({dec_block, dec_byte}),
		.i_width(i_word_width_select),
		.i_wdata(i_wdata),
		.i_peek_index(i_peek_index),
		.o_peek_data(o_peek_data)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Busy lasts cnt+1 cycles from the accepting edge
	always_comb begin
		st_nxt = st_r;
		unique case (st_r.state)
			FBWA_IDLE: begin
				if (acc) begin
					// Status changes only when an operation starts
					st_nxt.status = err; // see R14
					if (err == ST_OK) begin
						// Any good write leaves its block loaded
						st_nxt.blk_valid = 1'b1;
						st_nxt.blk = dec_block;
						if (!pg_hit) begin
							// Copy whole page; waits out a running prefetch
							st_nxt.state = FBWA_COPY; // see R09
							st_nxt.busy = 1'b1;
							st_nxt.cnt = CNT_W'(COPY_CYC - 1); // see R10
							// A prefetch in flight must finish before the copy
							if (i_prefetch_active) begin
								st_nxt.cnt = CNT_W'(COPY_CYC - 1 + PREFETCH_EXTRA);
							end
							// Buffer now names the new page; earlier bytes stay
							st_nxt.buf_valid = 1'b1;
							st_nxt.sector = dec_sector;
							st_nxt.page = dec_page;
							st_nxt.spare = i_spare_page_select;
						end else if (!blk_hit) begin
							// Store old block, load the new one
							st_nxt.state = FBWA_SWITCH; // see R12
							st_nxt.busy = 1'b1;
							st_nxt.cnt = i_pipe ? CNT_W'(SWITCH_PIPE_CYC - 1)
								: CNT_W'(SWITCH_CYC - 1);
						end
						// Else same block: done with no busy, see R11
					end
				end
			end
			FBWA_COPY, FBWA_SWITCH: begin
				// Count down, release busy on the last cycle
				if (st_r.cnt == '0) begin
					st_nxt.state = FBWA_IDLE;
					st_nxt.busy = 1'b0;
				end else begin
					st_nxt.cnt = st_r.cnt - CNT_W'(1);
				end
			end
			default: begin
				// Illegal code: recover to idle
				st_nxt.state = FBWA_IDLE;
				st_nxt.busy = 1'b0;
				st_nxt.cnt = '0;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= '{state: FBWA_IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// All straight from the state register
	assign o_busy = st_r.busy; // see R07
	assign o_status = st_r.status;
	assign o_buf_valid = st_r.buf_valid; // Lets the requester track, see R19
	assign o_buf_sector = st_r.sector;
	assign o_buf_page = st_r.page;
	assign o_buf_spare = st_r.spare;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Busy run length and its expected figure
	logic [CNT_W-1:0] run_r;
	logic [CNT_W-1:0] exp_r;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_r <= '0;
			exp_r <= '0;
		end else begin
			run_r <= o_busy ? run_r + CNT_W'(1) : '0;
			if (acc && err == ST_OK && !pg_hit) begin
				exp_r <= i_prefetch_active ? CNT_W'(COPY_CYC + PREFETCH_EXTRA)
					: CNT_W'(COPY_CYC);
			end
		end
	end

	// Named requests of a block switch and a page copy
	sequence s_switch_req;
		acc && err == ST_OK && pg_hit && !blk_hit;
	endsequence
	sequence s_copy_req;
		acc && err == ST_OK && !pg_hit;
	endsequence

	copy_length_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R09
		s_copy_req |=> o_busy [*8] ##0 (exp_r >= CNT_W'(COPY_CYC)))
		else $error("page copy expected figure wrong or no busy");
	copy_release_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R10
		$fell(o_busy) && st_r.buf_valid && run_r > CNT_W'(SWITCH_PIPE_CYC)
		|-> run_r == exp_r)
		else $error("page copy busy length wrong");
	switch_plain_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R12
		s_switch_req ##0 !i_pipe |=> o_busy [*4] ##1 !o_busy)
		else $error("block switch busy not four cycles");
	switch_pipe_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R12
		s_switch_req ##0 i_pipe |=> o_busy [*5] ##1 !o_busy)
		else $error("pipelined block switch busy not five cycles");
	same_block_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R11
		acc && err == ST_OK && blk_hit |=> !o_busy && o_status == ST_OK)
		else $error("same block write raised busy");
	protect_refuse_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R17
		acc && !dec_spare0 && i_page_protected
		|=> o_status == ST_PROTECT && !o_busy && $stable(o_buf_page))
		else $error("protected page write not refused");
	loss_refuse_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R18
		acc && !dec_spare0 && !i_page_protected && i_page_loss_protect && !pg_hit
		|=> o_status == ST_LOSS && !o_busy && $stable(o_buf_valid))
		else $error("page loss guard not applied");
	spare_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R06
		acc && dec_spare0 |=> o_status == ST_SPARE0 && !o_busy)
		else $error("sector zero spare write not refused");
	status_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R14
		!acc |=> $stable(o_status))
		else $error("status changed without a new operation");
	busy_drop_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R07
		o_busy && i_wen && st_r.cnt != '0 |=> o_busy && st_r.cnt == $past(st_r.cnt) - CNT_W'(1))
		else $error("strobe during busy disturbed the count");

	// ----------------------------------------
	// Checks on fields, identity and status
	// ----------------------------------------
	// A refused write must leave the buffered page identity alone
	refused_keep_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R13
		acc && err != ST_OK
		|=> $stable(o_buf_sector) && $stable(o_buf_page) && $stable(o_buf_spare))
		else $error("refused write moved the buffered page");
	// Every taken write shows its own result next cycle
	status_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R14
		acc |=> o_status == $past(err))
		else $error("status does not follow the taken write");
	// A page miss names the requested sector and page
	copy_target_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R03
		s_copy_req |=> o_buf_valid && o_buf_sector == $past(dec_sector)
		&& o_buf_page == $past(dec_page))
		else $error("copied page identity wrong");
	// Spare page keeps no page number
	spare_field_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R04
		s_copy_req ##0 i_spare_page_select |=> o_buf_spare && o_buf_page == '0)
		else $error("spare page field not ignored");
	// Aux block lands on index eight within four bytes
	aux_field_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R05
		i_aux_block_select |-> dec_block == AUX_BLOCK_IDX && dec_byte < BYTE_W'(AUX_BYTES))
		else $error("aux block address bits not ignored");
	// No busy run may outlast the longest copy
	busy_bound_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R09
		o_busy |-> run_r < CNT_W'(COPY_CYC + PREFETCH_EXTRA))
		else $error("busy held longer than a page copy");
	// A block switch stays inside the buffered page
	switch_keep_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R12
		s_switch_req |=> $stable(o_buf_page) && $stable(o_buf_sector))
		else $error("block switch moved the buffered page");
	// Loss guard never blocks a write to the buffered page
	loss_hit_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R18
		acc && !dec_spare0 && !i_page_protected && i_page_loss_protect && pg_hit
		|=> o_status == ST_OK)
		else $error("loss guard refused a buffered page");
	// The switched-to block becomes the loaded one
	switch_block_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R12
		s_switch_req |=> st_r.blk_valid && st_r.blk == $past(dec_block))
		else $error("new block not loaded after switch");
	// Busy only ever starts from a taken, good write
	busy_start_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R07
		$rose(o_busy) |-> $past(acc) && $past(err) == ST_OK)
		else $error("busy rose without a taken write");
	// Buffer identity only moves on a page miss
	buf_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R09
		!(acc && err == ST_OK && !pg_hit)
		|=> $stable(o_buf_sector) && $stable(o_buf_page) && $stable(o_buf_valid))
		else $error("buffer identity changed without a miss");
	// Busy and sequencer state agree
	busy_idle_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R07
		o_busy == (st_r.state != FBWA_IDLE))
		else $error("busy and sequencer state disagree");
	// Same block writes keep page and block
	hit_keep_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R11
		acc && err == ST_OK && blk_hit |=> $stable(o_buf_page) && st_r.blk == $past(st_r.blk))
		else $error("same block write moved page or block");
endmodule : fbwa_write_ctrl

// ---- include/fbwa_pkg.sv ----
// Shared constants and types for the flash block write access logic
package fbwa_pkg;
	// ----------------------------------------
	// Address layout
	// ----------------------------------------
	localparam int ADDR_W = 18;
	localparam int SECTOR_W = 6;
	localparam int PAGE_W = 5;
	localparam int BLOCK_W = 4; // Nine blocks need four bits
	localparam int BYTE_W = 4;
	localparam int SECTOR_HI = 17;
	localparam int SECTOR_LO = 12;
	localparam int PAGE_HI = 11;
	localparam int PAGE_LO = 7;
	localparam int BLOCK_HI = 6;
	localparam int BLOCK_LO = 4;
	localparam int BYTE_HI = 3;
	localparam int BYTE_LO = 0;
	localparam int AUX_BYTE_HI = 1; // Aux block keeps bits 1:0 only
	localparam int SECTORS = 64;
	localparam int PAGES = 32;
	localparam int DATA_BLOCKS = 8;
	localparam int BLOCK_BYTES = 16;
	localparam int AUX_BYTES = 4;
	localparam int BLOCKS_PER_PAGE = DATA_BLOCKS + 1;
	localparam int PAGE_BYTES = BLOCKS_PER_PAGE * BLOCK_BYTES;
	localparam int BUF_IDX_W = BLOCK_W + BYTE_W;
	localparam logic [BLOCK_W-1:0] AUX_BLOCK_IDX = 4'h8;
	localparam logic [SECTOR_W-1:0] SECTOR_ZERO = 6'h00;
	// ----------------------------------------
	// Data path
	// ----------------------------------------
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam logic [1:0] WW_BYTE = 2'h0;
	localparam logic [1:0] WW_HALF = 2'h1;
	localparam logic [1:0] WW_WORD = 2'h2;
	// ----------------------------------------
	// Busy timing, in clock cycles
	// ----------------------------------------
	localparam int BLK_READ_CYC = 5;
	localparam int BLK_WRITE_CYC = 1;
	localparam int RELOAD_CYC = 1;
	localparam int COPY_CYC = BLOCKS_PER_PAGE * (BLK_READ_CYC + BLK_WRITE_CYC) + RELOAD_CYC;
	localparam int SWITCH_CYC = 4;
	localparam int SWITCH_PIPE_CYC = 5;
	localparam int CNT_W = 7;
	// ----------------------------------------
	// Status codes and states
	// ----------------------------------------
	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_PROTECT = 2'h1;
	localparam logic [1:0] ST_SPARE0 = 2'h2;
	localparam logic [1:0] ST_LOSS = 2'h3;
	typedef enum logic [1:0] {
		FBWA_IDLE = 2'h0,
		FBWA_COPY = 2'h1,
		FBWA_SWITCH = 2'h2
	} fbwa_state_t;
endpackage : fbwa_pkg

// ---- hw/fbwa_addr_decode.sv ----
// Address field decoder for the flash block write access logic
`timescale 1ns/100ps
module fbwa_addr_decode (
	input wire logic [fbwa_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_spare_page_select,
	input wire logic i_aux_block_select,
	output logic [fbwa_pkg::SECTOR_W-1:0] o_sector,
	output logic [fbwa_pkg::PAGE_W-1:0] o_page,
	output logic [fbwa_pkg::BLOCK_W-1:0] o_block,
	output logic [fbwa_pkg::BYTE_W-1:0] o_byte,
	output logic o_spare0
);
	import fbwa_pkg::*;
	// ----------------------------------------
	// Field extraction
	// ----------------------------------------
	// Sector is always taken from the top bits
	assign o_sector = i_addr[SECTOR_HI:SECTOR_LO]; // see R03
	// Spare page has no page number, so the field is forced to zero
	assign o_page = i_spare_page_select ? '0 : i_addr[PAGE_HI:PAGE_LO]; // see R04
	// Aux block is block index eight, block bits are ignored
	assign o_block = i_aux_block_select ? AUX_BLOCK_IDX
		: {1'b0, i_addr[BLOCK_HI:BLOCK_LO]}; // see R05
	// Aux block holds four bytes, so only two byte bits count
	assign o_byte = i_aux_block_select ? {2'h0, i_addr[AUX_BYTE_HI:BYTE_LO]}
		: i_addr[BYTE_HI:BYTE_LO]; // see R02
	// Spare page of sector zero is reserved
	assign o_spare0 = i_spare_page_select && (o_sector == SECTOR_ZERO); // see R06
endmodule : fbwa_addr_decode

// ---- hw/fbwa_page_buffer.sv ----
// Page buffer storage with byte lanes and a registered peek port
`timescale 1ns/100ps
module fbwa_page_buffer (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_we,
	input wire logic i_aux,
	input wire logic [fbwa_pkg::BUF_IDX_W-1:0] i_index,
	input wire logic [1:0] i_width,
	input wire logic [fbwa_pkg::DATA_W-1:0] i_wdata,
	input wire logic [fbwa_pkg::BUF_IDX_W-1:0] i_peek_index,
	output logic [7:0] o_peek_data
);
	import fbwa_pkg::*;
	// All state of the buffer
	typedef struct packed {
		logic [PAGE_BYTES-1:0][7:0] mem; // Nine blocks of sixteen bytes
		logic [7:0] peek; // Registered peek byte
	} fbwa_pbuf_t;
	fbwa_pbuf_t st_r;
	fbwa_pbuf_t st_nxt;
	// ----------------------------------------
	// Lane writes and peek
	// ----------------------------------------
	// A word never spills into the next block; excess lanes drop
	always_comb begin
		int nbytes;
		int lim;
		nbytes = LANES;
		lim = i_aux ? AUX_BYTES - 1 : BLOCK_BYTES - 1;
		st_nxt = st_r;
		unique case (i_width)
			WW_BYTE: nbytes = 1;
			WW_HALF: nbytes = 2;
			default: nbytes = LANES;
		endcase
		for (int k = 0; k < LANES; k++) begin
			if (i_we && (k < nbytes) && (int'(i_index[BYTE_W-1:0]) + k <= lim)) begin
				st_nxt.mem[i_index + BUF_IDX_W'(k)] = i_wdata[8*k +: 8]; // see R15
			end
		end
		// Out-of-range peek reads zero
		if (int'(i_peek_index) < PAGE_BYTES) begin
			st_nxt.peek = st_r.mem[i_peek_index];
		end else begin
			st_nxt.peek = 8'h00;
		end
	end
	// State register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_peek_data = st_r.peek;
endmodule : fbwa_page_buffer

// ---- tb/fbwa_requester.sv ----
// Requester model that presents write operations to the access logic
`timescale 1ns/100ps
module fbwa_requester (
	input wire logic i_clk,
	input wire logic i_busy,
	output logic o_wen,
	output logic [fbwa_pkg::ADDR_W-1:0] o_addr,
	output logic [fbwa_pkg::DATA_W-1:0] o_wdata,
	output logic [1:0] o_width,
	output logic o_spare,
	output logic o_aux,
	output logic o_pipe,
	output logic o_prot,
	output logic o_loss,
	output logic o_pref
);
	logic hung = 1'b0; // Set when a wait ran out
	// ----------------------------------------
	// Idle levels at time zero
	// ----------------------------------------
	initial begin
		o_wen = 1'b0;
		o_addr = '0;
		o_wdata = '0;
		{o_width, o_spare, o_aux, o_pipe, o_prot, o_loss, o_pref} = '0;
	end
	// ----------------------------------------
	// One write, then count the busy cycles it costs
	// ----------------------------------------
	// Control bits: width, spare, aux, pipe, prot, loss, pref, poke
	task automatic do_write(input logic [17:0] a, input logic [31:0] d,
		input logic [8:0] c, output int n);
		int t;
		t = 0;
		while (i_busy !== 1'b0 && t < 200) begin
			@(negedge i_clk);
			t++;
		end
		if (t == 200) hung = 1'b1;
		o_addr = a;
		o_wdata = d;
		{o_width, o_spare, o_aux, o_pipe, o_prot, o_loss, o_pref} = c[8:1];
		o_wen = 1'b1;
		@(negedge i_clk);
		// Poke once while busy: must be ignored
		o_wen = c[0] && i_busy === 1'b1;
		// Released lines show inverted values, not stale ones
		o_wdata = ~d;
		o_addr = ~a;
		n = 0;
		while (i_busy === 1'b1 && n < 200) begin
			@(negedge i_clk);
			o_wen = 1'b0;
			n++;
		end
		if (n == 200) hung = 1'b1;
	endtask : do_write
endmodule : fbwa_requester

// ---- tb/tb.sv ----
// Self-checking bench for the flash block write access logic
`timescale 1ns/100ps
module tb;
	import fbwa_pkg::*;
	localparam int PX = 2; // Shortened prefetch wait
	logic i_clk, i_reset_n, wen, spare, aux, pipe, prot, loss, pref;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [1:0] width, o_status;
	logic [BUF_IDX_W-1:0] peek;
	logic o_busy, o_buf_valid, o_buf_spare;
	logic [SECTOR_W-1:0] o_buf_sector;
	logic [PAGE_W-1:0] o_buf_page;
	logic [7:0] o_peek_data;
	int n_fail = 0;
	int tests_run = 0;
	integer seed = 27761;
	logic [7:0] mem [PAGE_BYTES]; // Shadow of the page buffer
	int m_valid, m_sec, m_page, m_spare, m_blk, e_busy; // Model state
	logic [1:0] e_st;
	// ----------------------------------------
	// Design and requester
	// ----------------------------------------
	fbwa_write_ctrl #(.PREFETCH_EXTRA(PX)) fbwa_write_ctrl_inst (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_wen(wen), .i_addr(addr), .i_wdata(wdata),
		.i_word_width_select(width), .i_spare_page_select(spare),
		.i_aux_block_select(aux), .i_pipe(pipe), .i_page_protected(prot),
		.i_page_loss_protect(loss), .i_prefetch_active(pref), .i_peek_index(peek),
		.o_busy(o_busy), .o_status(o_status), .o_buf_valid(o_buf_valid),
		.o_buf_sector(o_buf_sector), .o_buf_page(o_buf_page),
		.o_buf_spare(o_buf_spare), .o_peek_data(o_peek_data));
	fbwa_requester fbwa_requester_inst (.i_clk(i_clk), .i_busy(o_busy), .o_wen(wen),
		.o_addr(addr), .o_wdata(wdata), .o_width(width), .o_spare(spare),
		.o_aux(aux), .o_pipe(pipe), .o_prot(prot), .o_loss(loss), .o_pref(pref));
	// ----------------------------------------
	// Compare and close
	// ----------------------------------------
	task automatic check_bus(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t value %h, expected %h", $time, got, exp);
		end
	endtask : check_bus
	task automatic check_cnt(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			n_fail++;
			$display("[ERR] %0t busy cycles %0d, expected %0d", $time, got, exp);
		end
	endtask : check_cnt
	task automatic complete_run;
		if (fbwa_requester_inst.hung) n_fail++;
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// Reference model of one write
	// ----------------------------------------
	task automatic model(input logic [17:0] a, input logic [31:0] d, input logic [8:0] c);
		int sec, pg, bk, by, miss, lim, n;
		sec = a[17:12];
		pg = c[6] ? 0 : a[11:7];
		bk = c[5] ? 8 : a[6:4];
		by = c[5] ? a[1:0] : a[3:0];
		miss = !m_valid || sec != m_sec || pg != m_page || c[6] != m_spare;
		e_busy = 0;
		if (c[6] && sec == 0) e_st = ST_SPARE0;
		else if (c[3]) e_st = ST_PROTECT;
		else if (c[2] && miss) e_st = ST_LOSS;
		else begin
			e_st = 2'h0;
			// Copy is nine blocks of 5+1 cycles plus one reload
			if (miss) e_busy = 9 * 6 + 1 + (c[1] ? PX : 0);
			else if (bk != m_blk) e_busy = c[4] ? 5 : 4;
			m_valid = 1;
			m_sec = sec;
			m_page = pg;
			m_spare = c[6];
			m_blk = bk;
			n = c[8:7] == 2'h0 ? 1 : c[8:7] == 2'h1 ? 2 : 4;
			lim = c[5] ? 4 : 16;
			for (int k = 0; k < n; k++) begin
				if (by + k < lim) mem[bk * 16 + by + k] = d[8 * k +: 8];
			end
		end
	endtask : model
	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		logic [8:0] c;
		logic [17:0] a;
		logic [31:0] d;
		int nb, ix;
		i_reset_n = 1'b0;
		peek = '0;
		{m_valid, m_sec, m_page, m_spare, m_blk} = '0;
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (4) @(negedge i_clk);
		i_reset_n = 1'b1;
		check_bus(8'(o_busy), 8'h00);
		check_bus(8'(o_status), 8'h00);
		check_bus(8'(o_buf_valid), 8'h00);
		m_blk = -1;
		for (int i = 0; i < 300; i++) begin
			// Mid-run reset: buffer, status and model all start over
			if (i == 150) begin
				i_reset_n = 1'b0;
				@(negedge i_clk);
				i_reset_n = 1'b1;
				{m_valid, m_sec, m_page, m_spare} = '0;
				m_blk = -1;
				foreach (mem[j]) mem[j] = 8'h00;
				check_bus(8'(o_busy), 8'h00);
				check_bus(8'(o_status), 8'h00);
				check_bus(8'(o_buf_valid), 8'h00);
			end
			// Few pages and blocks, so hits and switches occur often
			a = $random(seed);
			a[17:13] = '0;
			a[11:8] = '0;
			a[6:5] = '0;
			d = $random(seed);
			c = $random(seed);
			c[3] = ($random(seed) & 7) == 0;
			c[2] = ($random(seed) & 3) == 0;
			fbwa_requester_inst.do_write(a, d, c, nb);
			if (fbwa_requester_inst.hung) complete_run;
			model(a, d, c);
			check_cnt(nb, e_busy);
			check_bus(8'(o_status), 8'(e_st));
			check_bus(8'(o_buf_valid), 8'(m_valid));
			check_bus(8'(o_buf_sector), 8'(m_sec));
			check_bus(8'(o_buf_page), 8'(m_page));
			check_bus(8'(o_buf_spare), 8'(m_spare));
			ix = {$random(seed)} % 150;
			peek = ix[7:0];
			@(negedge i_clk);
			check_bus(o_peek_data, ix < 144 ? mem[ix] : 8'h00);
		end
		complete_run;
	end
endmodule : tb
